// *** rtl/splat_top.sv ***
// serial port strap latch with ahb-lite control registers
//
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`include "splat_consts.svh"
// Notes on behaviour
// - even strap 0 powers port n; 1 kills both
// - even setting drives all four pair lanes
// - odd strap sets port n+1 unless forced
// - power straps ignored after sampling window
// - quad override replaces latched even strap
// - single override replaces latched odd strap
// - rate codes 00,01,10 legal; 11 illegal
// - rate code applies to every port
// - rate applied after hard or self reset
// - rate straps latched in window; software may override
// - rate field shows sampled strap after reset; an illegal 11 reads back as 10
// - strap drivers enabled only in test mode
// - mode strap 0 quad, 1 dual single
module splat_top
  import splat_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire logic                      test_mode,
  input  wire logic [`SPLAT_NPAIR-1:0]   even_port_powerdown_strap,
  input  wire logic [`SPLAT_NPAIR-1:0]   odd_port_powerdown_strap,
  input  wire logic [`SPLAT_NPAIR-1:0]   pair_mode_strap,
  input  wire logic [1:0]                line_rate_strap,
  output logic      [`SPLAT_NPAIR-1:0]   strap_pd_even_out,
  output logic      [`SPLAT_NPAIR-1:0]   strap_pd_odd_out,
  output logic      [`SPLAT_NPAIR-1:0]   strap_pd_oe,
  output logic      [1:0]                strap_rate_out,
  output logic                           strap_rate_oe,
  output logic      [4*`SPLAT_NPAIR-1:0] lane_powerdown,
  output logic      [2*`SPLAT_NPAIR-1:0] port_powerdown,
  output logic      [2*`SPLAT_NPAIR-1:0] port_quad_mode,
  output logic      [1:0]                line_rate,
  output logic                           self_reset_busy
);
  typedef struct packed {
    splat_state_t             st;
    logic [`SPLAT_CNT_W-1:0]  cnt;
    logic                     wr_pend;
    logic                     rd_pend;
    logic [3:0]               addr;
    logic [1:0]               ov_rate;
    logic                     ov_rate_en;
    logic [`SPLAT_NPAIR-1:0]  quad_lane_powerdown_override;
    logic [`SPLAT_NPAIR-1:0]  single_lane_powerdown_override;
    logic [`SPLAT_NPAIR-1:0]  ov_en;
    logic                     test_drive;
    logic                     done;
    logic [31:0]              rdata;
    logic [2*`SPLAT_NPAIR-1:0] port_pd;
    logic [4*`SPLAT_NPAIR-1:0] lane_pd;
    logic [1:0]               rate;
  } splat_top_t;

  splat_top_t   s;
  splat_top_t   next_s;
  splat_latch_t lat;
  logic         load;
  logic         req;
  logic [31:0]  ctrl_word;
  logic [31:0]  stat_word;
  logic [31:0]  strap_word;
  logic [`SPLAT_NPAIR-1:0] eff_even;
  logic [`SPLAT_NPAIR-1:0] eff_odd;
  localparam int load_gap = `SPLAT_HOLD_CYC - 1;

  // capture at the end of the sampling window
  assign load = (s.st == SPLAT_SAMPLE) && (s.cnt == `SPLAT_CNT_W'(`SPLAT_HOLD_CYC - 1));
  assign req  = hsel && hready && (htrans == `SPLAT_HTRANS_NONSEQ);

  splat_strap_reg u_strap (
    .clk     (clk),
    .nrst    (nrst),
    .load    (load),
    .even_in (even_port_powerdown_strap),
    .odd_in  (odd_port_powerdown_strap),
    .mode_in (pair_mode_strap),
    .rate_in (line_rate_strap),
    .q       (lat)
  );

  // overrides replace the latched power straps
  generate
    for (genvar p = 0; p < `SPLAT_NPAIR; p++)
    begin : g_ovr
      assign eff_even[p] = s.ov_en[p] ? s.quad_lane_powerdown_override[p] : lat.even_pd[p];
      assign eff_odd[p]  = s.ov_en[p] ? s.single_lane_powerdown_override[p] : lat.odd_pd[p];
    end
  endgenerate

  always_comb
  begin
    ctrl_word = 32'h0;
    ctrl_word[`SPLAT_CTRL_RATE_HI:`SPLAT_CTRL_RATE_LO] = s.ov_rate;
    ctrl_word[`SPLAT_CTRL_RATE_EN] = s.ov_rate_en;
    ctrl_word[`SPLAT_CTRL_X4_BASE +: `SPLAT_NPAIR] = s.quad_lane_powerdown_override;
    ctrl_word[`SPLAT_CTRL_X1_BASE +: `SPLAT_NPAIR] = s.single_lane_powerdown_override;
    ctrl_word[`SPLAT_CTRL_OV_BASE +: `SPLAT_NPAIR] = s.ov_en;
    ctrl_word[`SPLAT_CTRL_TEST] = s.test_drive;
    ctrl_word[`SPLAT_CTRL_SRST] = (s.st != SPLAT_RUN);
    stat_word = 32'h0;
    stat_word[`SPLAT_CTRL_RATE_HI:`SPLAT_CTRL_RATE_LO] = s.rate;
    stat_word[`SPLAT_STAT_BADRATE + 2] = lat.bad_rate;
    stat_word[`SPLAT_STAT_DONE + 2] = s.done;
    stat_word[`SPLAT_CTRL_X4_BASE +: `SPLAT_NPAIR] = lat.even_pd;
    stat_word[`SPLAT_CTRL_X1_BASE +: `SPLAT_NPAIR] = lat.odd_pd;
    stat_word[`SPLAT_CTRL_OV_BASE +: `SPLAT_NPAIR] = lat.mode;
    strap_word = 32'h0;
    strap_word[1:0] = lat.rate;
    strap_word[`SPLAT_CTRL_X4_BASE +: `SPLAT_NPAIR] = lat.even_pd;
  end

  always_comb
  begin
    next_s = s;
    next_s.wr_pend = 1'b0;
    next_s.rd_pend = 1'b0;
    case (s.st)
      SPLAT_IDLE:
      begin
        next_s.st  = SPLAT_SAMPLE;
        next_s.cnt = '0;
      end
      SPLAT_SAMPLE:
      begin
        next_s.cnt = s.cnt + `SPLAT_CNT_W'(1);
        if (load)
        begin
          next_s.st   = SPLAT_RUN;
          next_s.done = 1'b1;
        end
      end
      SPLAT_RUN:
        next_s.st = SPLAT_RUN;
      default:
        next_s.st = SPLAT_IDLE;
    endcase
    // data phase of a write
    if (s.wr_pend && s.addr == `SPLAT_ADDR_CTRL)
    begin
      next_s.ov_rate    = hwdata[`SPLAT_CTRL_RATE_HI:`SPLAT_CTRL_RATE_LO];
      next_s.ov_rate_en = hwdata[`SPLAT_CTRL_RATE_EN];
      next_s.quad_lane_powerdown_override   = hwdata[`SPLAT_CTRL_X4_BASE +: `SPLAT_NPAIR];
      next_s.single_lane_powerdown_override = hwdata[`SPLAT_CTRL_X1_BASE +: `SPLAT_NPAIR];
      next_s.ov_en      = hwdata[`SPLAT_CTRL_OV_BASE +: `SPLAT_NPAIR];
      next_s.test_drive = hwdata[`SPLAT_CTRL_TEST];
      if (hwdata[`SPLAT_CTRL_SRST])
      begin
        next_s.st         = SPLAT_IDLE; // self reset
        next_s.done       = 1'b0;
        next_s.ov_rate_en = 1'b0;
        next_s.ov_en      = '0;
      end
    end
    if (req)
    begin
      next_s.addr    = haddr[3:0];
      next_s.wr_pend = hwrite;
      next_s.rd_pend = !hwrite;
      case (haddr[3:0])
        `SPLAT_ADDR_CTRL:  next_s.rdata = ctrl_word;
        `SPLAT_ADDR_STAT:  next_s.rdata = stat_word;
        `SPLAT_ADDR_STRAP: next_s.rdata = strap_word;
        default:           next_s.rdata = 32'h0;
      endcase
    end
    // single rate for all ports
    next_s.rate = s.ov_rate_en ? s.ov_rate : lat.rate;
    for (int p = 0; p < `SPLAT_NPAIR; p++)
    begin
      next_s.port_pd[2*p]   = eff_even[p];
      next_s.port_pd[2*p+1] = eff_even[p] | eff_odd[p];
      next_s.lane_pd[4*p +: 4] = {4{eff_even[p]}};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s.st         <= SPLAT_IDLE;
      s.cnt        <= '0;
      s.wr_pend    <= 1'b0;
      s.rd_pend    <= 1'b0;
      s.addr       <= 4'h0;
      s.ov_rate    <= `SPLAT_RATE_3G125;
      s.ov_rate_en <= 1'b0;
      s.quad_lane_powerdown_override   <= '0;
      s.single_lane_powerdown_override <= '0;
      s.ov_en      <= '0;
      s.test_drive <= 1'b0;
      s.done       <= 1'b0;
      s.rdata      <= 32'h0;
      s.port_pd    <= '1;
      s.lane_pd    <= '1;
      s.rate       <= `SPLAT_RATE_3G125;
    end
    else
      s <= next_s;
  end

  assign hrdata          = s.rdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign port_powerdown  = s.port_pd;
  assign lane_powerdown  = s.lane_pd;
  assign line_rate       = s.rate;
  assign self_reset_busy = (s.st != SPLAT_RUN);

  // mode strap: 0 gives quad lanes on port n
  generate
    for (genvar p = 0; p < `SPLAT_NPAIR; p++)
    begin : g_mode
      assign port_quad_mode[2*p]   = !lat.mode[p];
      assign port_quad_mode[2*p+1] = 1'b0;
    end
  endgenerate

  // pin drivers only in test mode
  assign strap_pd_oe       = {`SPLAT_NPAIR{test_mode & s.test_drive}};
  assign strap_rate_oe     = test_mode & s.test_drive;
  assign strap_pd_even_out = lat.even_pd;
  assign strap_pd_odd_out  = lat.odd_pd;
  assign strap_rate_out    = lat.rate;

  sequence seq_load;
    load ##1 (s.st == SPLAT_RUN);
  endsequence

  sequence seq_srst_write;
    s.wr_pend && (s.addr == `SPLAT_ADDR_CTRL) && hwdata[`SPLAT_CTRL_SRST];
  endsequence

  sequence seq_restart;
    (s.st == SPLAT_IDLE && !s.done && s.ov_en == '0 && !s.ov_rate_en) ##1 (s.cnt == '0);
  endsequence

  a_test_drive: assert property (@(posedge clk) disable iff (!nrst)
    !test_mode |-> (strap_pd_oe == '0 && !strap_rate_oe))
    else $error("strap driver on outside test mode");
  a_even_both: assert property (@(posedge clk) disable iff (!nrst)
    eff_even[0] |=> (port_powerdown[1:0] == 2'h3))
    else $error("even powerdown not applied to pair");
  a_odd_port: assert property (@(posedge clk) disable iff (!nrst)
    (!eff_even[0] && !eff_odd[0]) |=> !port_powerdown[1])
    else $error("odd port not powered up");
  a_lane_all: assert property (@(posedge clk) disable iff (!nrst)
    lane_powerdown[3:0] == {4{port_powerdown[0]}})
    else $error("lanes disagree with even port");
  a_strap_hold: assert property (@(posedge clk) disable iff (!nrst)
    (s.st == SPLAT_RUN && $past(s.st) == SPLAT_RUN) |-> $stable(lat))
    else $error("latched straps changed after window");
  a_load_time: assert property (@(posedge clk) disable iff (!nrst)
    (s.st == SPLAT_IDLE) |=> (s.st == SPLAT_SAMPLE) ##load_gap seq_load)
    else $error("sampling window length wrong");
  a_rate_legal: assert property (@(posedge clk) disable iff (!nrst)
    lat.rate != `SPLAT_RATE_BAD)
    else $error("illegal rate latched");
  a_rate_apply: assert property (@(posedge clk) disable iff (!nrst)
    (!s.ov_rate_en && $past(s.st) == SPLAT_RUN) |=> (line_rate == $past(lat.rate)))
    else $error("line rate differs from strap");
  a_self_reset: assert property (@(posedge clk) disable iff (!nrst)
    seq_srst_write |=> seq_restart)
    else $error("self reset did not restart sampling");
  a_window_step: assert property (@(posedge clk) disable iff (!nrst)
    (s.st == SPLAT_SAMPLE && !load && !s.wr_pend) |=>
    (s.st == SPLAT_SAMPLE && s.cnt == $past(s.cnt) + `SPLAT_CNT_W'(1)))
    else $error("sampling window left early");
  a_run_done: assert property (@(posedge clk) disable iff (!nrst)
    (s.st == SPLAT_RUN) |-> s.done)
    else $error("running without latch done");
  a_busy_after: assert property (@(posedge clk) disable iff (!nrst)
    load |=> !self_reset_busy)
    else $error("busy still high after capture");
  a_latch_quiet: assert property (@(posedge clk) disable iff (!nrst)
    !load |=> $stable(lat))
    else $error("latched straps changed without capture");
  a_latch_even: assert property (@(posedge clk) disable iff (!nrst)
    load |=> (lat.even_pd == $past(even_port_powerdown_strap)))
    else $error("even strap captured wrong");
  a_latch_odd: assert property (@(posedge clk) disable iff (!nrst)
    load |=> (lat.odd_pd == $past(odd_port_powerdown_strap)))
    else $error("odd strap captured wrong");
  a_latch_mode: assert property (@(posedge clk) disable iff (!nrst)
    load |=> (lat.mode == $past(pair_mode_strap)))
    else $error("mode strap captured wrong");
  a_latch_rate: assert property (@(posedge clk) disable iff (!nrst)
    (load && line_rate_strap != `SPLAT_RATE_BAD) |=> (lat.rate == $past(line_rate_strap)))
    else $error("rate strap captured wrong");
  a_bad_fallback: assert property (@(posedge clk) disable iff (!nrst)
    (load && line_rate_strap == `SPLAT_RATE_BAD) |=> (lat.bad_rate && lat.rate == `SPLAT_RATE_3G125))
    else $error("illegal rate not replaced or flagged");
  a_bad_clear: assert property (@(posedge clk) disable iff (!nrst)
    (load && line_rate_strap != `SPLAT_RATE_BAD) |=> !lat.bad_rate)
    else $error("illegal rate flag on legal code");
  a_even_pair1: assert property (@(posedge clk) disable iff (!nrst)
    eff_even[1] |=> (port_powerdown[3:2] == 2'h3))
    else $error("even powerdown not applied to second pair");
  a_even_up: assert property (@(posedge clk) disable iff (!nrst)
    !eff_even[0] |=> !port_powerdown[0])
    else $error("even port not powered up");
  a_odd_down: assert property (@(posedge clk) disable iff (!nrst)
    eff_odd[0] |=> port_powerdown[1])
    else $error("odd port not powered down");
  a_odd_pair1: assert property (@(posedge clk) disable iff (!nrst)
    (!eff_even[1] && !eff_odd[1]) |=> !port_powerdown[3])
    else $error("second pair odd port not powered up");
  a_lane_pair1: assert property (@(posedge clk) disable iff (!nrst)
    lane_powerdown[7:4] == {4{port_powerdown[2]}})
    else $error("second pair lanes disagree with even port");
  a_quad_odd: assert property (@(posedge clk) disable iff (!nrst)
    !port_quad_mode[1] && !port_quad_mode[3])
    else $error("odd port marked quad");
  a_quad_even: assert property (@(posedge clk) disable iff (!nrst)
    (port_quad_mode[0] == !lat.mode[0]) && (port_quad_mode[2] == !lat.mode[1]))
    else $error("quad mode disagrees with mode strap");
  a_rate_ovr: assert property (@(posedge clk) disable iff (!nrst)
    s.ov_rate_en |=> (line_rate == $past(s.ov_rate)))
    else $error("rate override not applied");
  a_oe_same: assert property (@(posedge clk) disable iff (!nrst)
    strap_pd_oe == {`SPLAT_NPAIR{strap_rate_oe}})
    else $error("strap drivers enabled unevenly");
  a_bus_okay: assert property (@(posedge clk) disable iff (!nrst)
    hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_ovr_even: assert property (@(posedge clk) disable iff (!nrst)
    (s.ov_en[1] && !s.quad_lane_powerdown_override[1]) |=> !port_powerdown[2])
    else $error("quad override not applied");
  a_ovr_odd: assert property (@(posedge clk) disable iff (!nrst)
    (s.ov_en[1] && !s.quad_lane_powerdown_override[1] && !s.single_lane_powerdown_override[1])
    |=> !port_powerdown[3])
    else $error("single override not applied");
endmodule

// *** rtl/splat_consts.svh ***
// constants for the serial port strap latch
`ifndef SPLAT_CONSTS_SVH
`define SPLAT_CONSTS_SVH
`define SPLAT_NPAIR          2
`define SPLAT_HOLD_NS        100
`define SPLAT_CLK_NS         10
`define SPLAT_HOLD_CYC       ((`SPLAT_HOLD_NS + `SPLAT_CLK_NS - 1) / `SPLAT_CLK_NS)
`define SPLAT_CNT_W          4
`define SPLAT_RATE_1G25      2'h0
`define SPLAT_RATE_2G5       2'h1
`define SPLAT_RATE_3G125     2'h2
`define SPLAT_RATE_BAD       2'h3
`define SPLAT_ADDR_CTRL      4'h0
`define SPLAT_ADDR_STAT      4'h4
`define SPLAT_ADDR_STRAP     4'h8
`define SPLAT_CTRL_RATE_LO   0
`define SPLAT_CTRL_RATE_HI   1
`define SPLAT_CTRL_RATE_EN   2
`define SPLAT_CTRL_X4_BASE   4
`define SPLAT_CTRL_X1_BASE   8
`define SPLAT_CTRL_OV_BASE   12
`define SPLAT_CTRL_TEST      16
`define SPLAT_CTRL_SRST      17
`define SPLAT_STAT_BADRATE   0
`define SPLAT_STAT_DONE      1
`define SPLAT_HTRANS_NONSEQ  2'h2
`endif

// *** rtl/splat_pkg.sv ***
// types for the serial port strap latch
`include "splat_consts.svh"
package splat_pkg;
  typedef enum logic [2:0] {
    SPLAT_IDLE   = 3'b001,
    SPLAT_SAMPLE = 3'b010,
    SPLAT_RUN    = 3'b100
  } splat_state_t;
  typedef struct packed {
    logic [`SPLAT_NPAIR-1:0] even_pd;
    logic [`SPLAT_NPAIR-1:0] odd_pd;
    logic [`SPLAT_NPAIR-1:0] mode;
    logic [1:0]              rate;
    logic                    bad_rate;
  } splat_latch_t;
endpackage

// *** rtl/splat_strap_reg.sv ***
// strap capture register, loaded only on a capture strobe
`timescale 1ns/1ps
`include "splat_consts.svh"
module splat_strap_reg
  import splat_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    load,
  input  wire logic [`SPLAT_NPAIR-1:0] even_in,
  input  wire logic [`SPLAT_NPAIR-1:0] odd_in,
  input  wire logic [`SPLAT_NPAIR-1:0] mode_in,
  input  wire logic [1:0]              rate_in,
  output splat_latch_t                 q
);
  splat_latch_t r;
  splat_latch_t next_r;
  always_comb
  begin
    next_r = r;
    if (load)
    begin
      next_r.even_pd  = even_in;
      next_r.odd_pd   = odd_in;
      next_r.mode     = mode_in;
      // illegal code falls back to default and is flagged
      next_r.bad_rate = (rate_in == `SPLAT_RATE_BAD);
      next_r.rate     = next_r.bad_rate ? `SPLAT_RATE_3G125 : rate_in;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      r.even_pd  <= {`SPLAT_NPAIR{1'b1}};
      r.odd_pd   <= {`SPLAT_NPAIR{1'b1}};
      r.mode     <= {`SPLAT_NPAIR{1'b1}};
      r.rate     <= `SPLAT_RATE_3G125;
      r.bad_rate <= 1'b0;
    end
    else
      r <= next_r;
  end
  assign q = r;
endmodule

// *** bench/splat_board.sv ***
// board strap tie-offs with test-mode pin resolution
`timescale 1ns/1ps
`include "splat_consts.svh"
module splat_board
  import splat_pkg::*;
(
  input  wire logic                    hold,
  input  wire logic [`SPLAT_NPAIR-1:0] cfg_even,
  input  wire logic [`SPLAT_NPAIR-1:0] cfg_odd,
  input  wire logic [`SPLAT_NPAIR-1:0] cfg_mode,
  input  wire logic [1:0]              cfg_rate,
  input  wire logic [`SPLAT_NPAIR-1:0] pd_oe,
  input  wire logic [`SPLAT_NPAIR-1:0] even_drv,
  input  wire logic [`SPLAT_NPAIR-1:0] odd_drv,
  input  wire logic                    rate_oe,
  input  wire logic [1:0]              rate_drv,
  output logic      [`SPLAT_NPAIR-1:0] even_pin,
  output logic      [`SPLAT_NPAIR-1:0] odd_pin,
  output logic      [`SPLAT_NPAIR-1:0] mode_pin,
  output logic      [1:0]              rate_pin
);
  // tie level, flipped once the hold window is over
  logic [`SPLAT_NPAIR-1:0] ev_tie;
  logic [`SPLAT_NPAIR-1:0] od_tie;
  assign ev_tie = hold ? cfg_even : ~cfg_even;
  assign od_tie = hold ? cfg_odd : ~cfg_odd;
  assign mode_pin = hold ? cfg_mode : ~cfg_mode;
  // device driver wins over the resistor
  assign even_pin = (pd_oe & even_drv) | (~pd_oe & ev_tie);
  assign odd_pin = (pd_oe & odd_drv) | (~pd_oe & od_tie);
  assign rate_pin = rate_oe ? rate_drv : (hold ? cfg_rate : ~cfg_rate);
endmodule

// *** bench/splat_top_bench.sv ***
// self-checking bench for the strap latch
`timescale 1ns/1ps
`include "splat_consts.svh"
module splat_top_bench
  import splat_pkg::*;
;
  typedef struct packed {
    logic [1:0] e, o, m, r;
    logic [3:0] pd;
    logic [7:0] ln;
    logic [3:0] qd;
    logic [1:0] xr;
    logic       bad;
  } splat_row_t;
  // odd strap high wherever a pair is quad
  localparam splat_row_t rows [4] = '{
    '{2'h0, 2'h0, 2'h3, 2'h0, 4'h0, 8'h00, 4'h0, 2'h0, 1'b0},
    '{2'h1, 2'h3, 2'h2, 2'h1, 4'hb, 8'h0f, 4'h1, 2'h1, 1'b0},
    '{2'h2, 2'h3, 2'h1, 2'h2, 4'he, 8'hf0, 4'h4, 2'h2, 1'b0},
    '{2'h0, 2'h3, 2'h0, 2'h3, 4'ha, 8'h00, 4'h5, 2'h2, 1'b1}};
  logic        clk, nrst, hsel, hwrite, hready, hreadyout, hresp, test_mode, hold, rate_oe, busy;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, ce, co, cm, cr, e_pin, o_pin, m_pin, r_pin, e_drv, o_drv, r_drv;
  logic [1:0]  pd_oe, lrate;
  logic [2:0]  hsize;
  logic [7:0]  lane;
  logic [3:0]  ppd, quad;
  int          err_total, num_checks, cyc;
  assign hready = hreadyout;
  splat_top dut_u (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .test_mode, .even_port_powerdown_strap(e_pin),
    .odd_port_powerdown_strap(o_pin), .pair_mode_strap(m_pin), .line_rate_strap(r_pin),
    .strap_pd_even_out(e_drv), .strap_pd_odd_out(o_drv), .strap_pd_oe(pd_oe),
    .strap_rate_out(r_drv), .strap_rate_oe(rate_oe), .lane_powerdown(lane),
    .port_powerdown(ppd), .port_quad_mode(quad), .line_rate(lrate), .self_reset_busy(busy));
  splat_board board_u (.hold, .cfg_even(ce), .cfg_odd(co), .cfg_mode(cm), .cfg_rate(cr),
    .pd_oe, .even_drv(e_drv), .odd_drv(o_drv), .rate_oe, .rate_drv(r_drv),
    .even_pin(e_pin), .odd_pin(o_pin), .mode_pin(m_pin), .rate_pin(r_pin));
  always #5 clk = ~clk;
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // single word transfer, waits on hready in both phases
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= `SPLAT_HTRANS_NONSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rst();
    @(posedge clk);
    nrst <= 1'b0;
    hold <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("rst_pd", ppd, 4'hf);
    chk("rst_rate", lrate, 2'h2);
    chk("rst_busy", busy, 1'b1);
    chk("rst_oe", pd_oe, 2'h0);
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
  endtask
  initial
  begin
    clk = 0; nrst = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
    hwdata = 0; test_mode = 0; hold = 1; ce = 0; co = 0; cm = 0; cr = 0;
    for (int i = 0; i < 4; i++)
    begin
      ce <= rows[i].e;
      co <= rows[i].o;
      cm <= rows[i].m;
      cr <= rows[i].r;
      rst();
      repeat (14) @(posedge clk);
      hold <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("port_pd", ppd, rows[i].pd);
      chk("lane_pd", lane, rows[i].ln);
      chk("quad", quad, rows[i].qd);
      chk("rate", lrate, rows[i].xr);
      chk("busy", busy, 1'b0);
      ahb(1'b0, `SPLAT_ADDR_STAT, 0, rd);
      chk("stat", {rd[5:4], rd[3:0]}, {rows[i].e, 1'b1, rows[i].bad, rows[i].xr});
      ahb(1'b0, `SPLAT_ADDR_STRAP, 0, rd);
      chk("strap_rate", rd[1:0], rows[i].xr);
    end
    ahb(1'b1, `SPLAT_ADDR_CTRL, 32'h0000_3014, rd);
    repeat (3) @(posedge clk);
    #1;
    chk("ov_pd", ppd, 4'h3);
    chk("ov_lane", lane, 8'h0f);
    chk("ov_rate", lrate, 2'h0);
    ahb(1'b0, `SPLAT_ADDR_CTRL, 0, rd);
    chk("ctrl", rd, 32'h0000_3014);
    ahb(1'b0, 32'h0000_000c, 0, rd);
    chk("unmapped", rd, 32'h0);
    chk("hresp", hresp, 1'b0);
    for (int j = 1; j < 4; j++)
    begin
      test_mode <= j[0];
      ahb(1'b1, `SPLAT_ADDR_CTRL, 32'h0000_3014 | {15'h0, j[1], 16'h0}, rd);
      repeat (3) @(posedge clk);
      #1;
      chk("pd_oe", pd_oe, {2{j == 3}});
      chk("rate_oe", rate_oe, j == 3);
    end
    chk("drv_rate", r_pin, 2'h2);
    chk("drv_even", e_pin, 2'h0);
    chk("drv_odd", o_pin, 2'h3);
    test_mode <= 1'b0;
    ce <= 2'h3;
    co <= 2'h3;
    cr <= 2'h1;
    hold <= 1'b1;
    ahb(1'b1, `SPLAT_ADDR_CTRL, 32'h0002_0000, rd);
    repeat (2) @(posedge clk);
    #1;
    chk("busy_sr", busy, 1'b1);
    for (int k = 0; k < 30 && busy !== 1'b0; k++)
    begin
      @(posedge clk);
      #1;
    end
    chk("sr_done", busy, 1'b0);
    repeat (2) @(posedge clk);
    hold <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("sr_pd", ppd, 4'hf);
    chk("sr_lane", lane, 8'hff);
    chk("sr_rate", lrate, 2'h1);
    tally_and_finish();
  end
endmodule
